// [verilog/aotp_regs.sv]
// Output mode and test pattern register bank behind the serial configuration port.
// Assumes raw pins from outside; samples arrive on the same clock.
`timescale 1ns/1ps
`include "aotp_defines.svh"

// Function
// R01: Bits 7-5 of output mode pick driver current; code 011 is unused.
// R02: Bit 4 turns on internal termination and doubles driver current.
// R03: Host enables termination only with 1.75, 2.1 or 2.5 mA current.
// R04: Bit 3 of output mode set disables the digital outputs.
// R05: Bits 2-0 pick lanes and serialization width; 011 and 100 unused.
// R06: Bit 7 of register 03h turns the digital test pattern on.
// R07: Bits 5-0 of register 03h form pattern bits 13 down to 8.
// R08: Bits 7-0 of register 04h form pattern bits 7 down to 0.
// R09: Bit 6 of register 03h is don't care and is ignored.
// R10: With pattern on, both channels send the pattern in current format.
// R11: Each access is a 16-bit word: read flag, 7-bit address, 8 data bits.
// R12: A software reset command clears every register data bit to zero.
module aotp_regs (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	input wire aotp_pkg::aotp_sample_t ch1_sample,
	input wire aotp_pkg::aotp_sample_t ch2_sample,
	output aotp_pkg::aotp_sample_t ch1_word,
	output aotp_pkg::aotp_sample_t ch2_word,
	output logic [7:0] drive_current_x50ua,
	output logic current_valid,
	output logic internal_termination_on,
	output logic termination_misuse,
	output logic output_disable,
	output logic [2:0] lane_serialization_sel,
	output logic two_lane,
	output logic [4:0] ser_width,
	output logic format_valid,
	output logic test_pattern_on,
	output aotp_pkg::aotp_sample_t test_pattern
);
	import aotp_pkg::*;

	logic [1:0] cs_sync_reg;
	logic [1:0] sck_sync_reg;
	logic [1:0] sdi_sync_reg;
	aotp_byte_t omode_reg;
	aotp_byte_t tph_reg;
	aotp_byte_t tpl_reg;
	aotp_byte_t omode_next;
	aotp_sample_t pattern;
	logic sdo_level_reg;
	logic swrst;

	aotp_cmd_if cmd();

	// Current in 50 uA steps; zero marks the unused code.
	function automatic logic [7:0] cur_x50(input logic [2:0] code, input logic term);
		logic [7:0] base;
		base = 8'h00;
		case (aotp_cur_e'(code))
			AOTP_CUR_3P5: base = 8'h46;
			AOTP_CUR_4P0: base = 8'h50;
			AOTP_CUR_4P5: base = 8'h5A;
			AOTP_CUR_3P0: base = 8'h3C;
			AOTP_CUR_2P5: base = 8'h32;
			AOTP_CUR_2P1: base = 8'h2A;
			AOTP_CUR_1P75: base = 8'h23;
			default: base = 8'h00;
		endcase
		cur_x50 = term ? {base[6:0], 1'b0} : base;
	endfunction

	function automatic logic [4:0] width_of(input logic [2:0] code);
		case (aotp_lane_e'(code))
			AOTP_L2_16, AOTP_L1_16: width_of = 5'h10;
			AOTP_L2_14, AOTP_L1_14: width_of = 5'h0E;
			AOTP_L2_12, AOTP_L1_12: width_of = 5'h0C;
			default: width_of = 5'h00;
		endcase
	endfunction

	function automatic logic term_allowed(input logic [2:0] code);
		term_allowed = code == AOTP_CUR_1P75 || code == AOTP_CUR_2P1 || code == AOTP_CUR_2P5;
	endfunction

	// Pins are asynchronous to the encode clock, hence two stages each.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cs_sync_reg <= 2'h3;
			sck_sync_reg <= 2'h0;
			sdi_sync_reg <= 2'h0;
		end else begin
			cs_sync_reg <= {cs_sync_reg[0], cs_n};
			sck_sync_reg <= {sck_sync_reg[0], sck};
			sdi_sync_reg <= {sdi_sync_reg[0], sdi};
		end
	end

	aotp_shifter u_shifter (
		.clock(clock),
		.arst_n(arst_n),
		.cs_n(cs_sync_reg[1]),
		.sck(sck_sync_reg[1]),
		.sdi(sdi_sync_reg[1]),
		.cmd(cmd.shifter)
	);

	// The reset bit is never stored, so it reads back as zero afterwards.
	assign swrst = cmd.wr_stb && cmd.addr == `AOTP_ADDR_RESET && cmd.wdata[`AOTP_SWRST_BIT];

	always_comb begin
		omode_next = omode_reg;
		if (cmd.wr_stb && cmd.addr == `AOTP_ADDR_OUTPUT_MODE) begin
			omode_next = cmd.wdata;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			omode_reg <= `AOTP_REG_RESET;
		end else if (swrst) begin
			omode_reg <= `AOTP_REG_RESET; // see R12
		end else begin
			omode_reg <= omode_next;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tph_reg <= `AOTP_REG_RESET;
			tpl_reg <= `AOTP_REG_RESET;
		end else if (swrst) begin
			tph_reg <= `AOTP_REG_RESET; // see R12
			tpl_reg <= `AOTP_REG_RESET;
		end else if (cmd.wr_stb) begin
			if (cmd.addr == `AOTP_ADDR_TP_HIGH) begin
				tph_reg <= cmd.wdata & `AOTP_TPH_MASK; // see R09
			end
			if (cmd.addr == `AOTP_ADDR_TP_LOW) begin
				tpl_reg <= cmd.wdata;
			end
		end
	end

	// Unmapped and write-only addresses read back as zero.
	always_comb begin
		case (cmd.addr)
			`AOTP_ADDR_OUTPUT_MODE: cmd.rdata = omode_reg; // see R11
			`AOTP_ADDR_TP_HIGH: cmd.rdata = tph_reg;
			`AOTP_ADDR_TP_LOW: cmd.rdata = tpl_reg;
			default: cmd.rdata = 8'h00;
		endcase
	end

	assign pattern = {tph_reg[`AOTP_TPH_MSB:0], tpl_reg}; // see R07, see R08

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sdo_level_reg <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			sdo_level_reg <= 1'b0;
			sdo_oe <= cmd.sdo_oe;
		end
	end
	assign sdo_o = sdo_level_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			drive_current_x50ua <= 8'h00;
			current_valid <= 1'b0;
			internal_termination_on <= 1'b0;
			termination_misuse <= 1'b0;
		end else begin
			drive_current_x50ua <= cur_x50(omode_reg[`AOTP_CUR_MSB:`AOTP_CUR_LSB],
				omode_reg[`AOTP_TERM_BIT]); // see R01, see R02
			current_valid <= omode_reg[`AOTP_CUR_MSB:`AOTP_CUR_LSB] != AOTP_CUR_NONE; // see R01
			internal_termination_on <= omode_reg[`AOTP_TERM_BIT]; // see R02
			// Flags a host setting outside the allowed termination pairings.
			termination_misuse <= omode_reg[`AOTP_TERM_BIT] &&
				!term_allowed(omode_reg[`AOTP_CUR_MSB:`AOTP_CUR_LSB]); // see R03
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			output_disable <= 1'b0;
			lane_serialization_sel <= 3'h0;
			two_lane <= 1'b1;
			ser_width <= 5'h10;
			format_valid <= 1'b1;
		end else begin
			output_disable <= omode_reg[`AOTP_OFF_BIT]; // see R04
			lane_serialization_sel <= omode_reg[`AOTP_MODE_MSB:`AOTP_MODE_LSB]; // see R05
			two_lane <= ~omode_reg[`AOTP_MODE_MSB]; // see R05
			ser_width <= width_of(omode_reg[`AOTP_MODE_MSB:`AOTP_MODE_LSB]); // see R05
			format_valid <= width_of(omode_reg[`AOTP_MODE_MSB:`AOTP_MODE_LSB]) != 5'h00;
		end
	end

	// Disabled outputs hold zero words so no stale sample leaks out.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			test_pattern_on <= 1'b0;
			test_pattern <= 14'h0000;
			ch1_word <= 14'h0000;
			ch2_word <= 14'h0000;
		end else begin
			test_pattern_on <= tph_reg[`AOTP_TEST_BIT]; // see R06
			test_pattern <= pattern;
			if (omode_reg[`AOTP_OFF_BIT]) begin
				ch1_word <= 14'h0000; // see R04
				ch2_word <= 14'h0000;
			end else if (tph_reg[`AOTP_TEST_BIT]) begin
				ch1_word <= pattern; // see R10
				ch2_word <= pattern;
			end else begin
				ch1_word <= ch1_sample;
				ch2_word <= ch2_sample;
			end
		end
	end
endmodule // aotp_regs

// [verilog/aotp_defines.svh]
// Register addresses, field positions, reset values and serial word counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef AOTP_DEFINES_SVH
`define AOTP_DEFINES_SVH

`define AOTP_ADDR_W 7
`define AOTP_ADDR_RESET 7'h00
`define AOTP_ADDR_OUTPUT_MODE 7'h02
`define AOTP_ADDR_TP_HIGH 7'h03
`define AOTP_ADDR_TP_LOW 7'h04

`define AOTP_REG_RESET 8'h00
`define AOTP_SWRST_BIT 7
`define AOTP_CUR_MSB 7
`define AOTP_CUR_LSB 5
`define AOTP_TERM_BIT 4
`define AOTP_OFF_BIT 3
`define AOTP_MODE_MSB 2
`define AOTP_MODE_LSB 0
`define AOTP_TEST_BIT 7
`define AOTP_TPH_MSB 5
`define AOTP_TPH_MASK 8'hBF

`define AOTP_WORD_BITS 5'h10
`define AOTP_HDR_BITS 5'h08

`endif

// [verilog/aotp_pkg.sv]
// Types and field code enumerations of the output mode and test pattern registers.
// Assumes the defines header is on the include path.
`include "aotp_defines.svh"

package aotp_pkg;

	typedef logic [7:0] aotp_byte_t;
	typedef logic [13:0] aotp_sample_t;

	typedef enum logic [2:0] {
		AOTP_CUR_3P5 = 3'b000,
		AOTP_CUR_4P0 = 3'b001,
		AOTP_CUR_4P5 = 3'b010,
		AOTP_CUR_NONE = 3'b011,
		AOTP_CUR_3P0 = 3'b100,
		AOTP_CUR_2P5 = 3'b101,
		AOTP_CUR_2P1 = 3'b110,
		AOTP_CUR_1P75 = 3'b111
	} aotp_cur_e;

	typedef enum logic [2:0] {
		AOTP_L2_16 = 3'b000,
		AOTP_L2_14 = 3'b001,
		AOTP_L2_12 = 3'b010,
		AOTP_LX_011 = 3'b011,
		AOTP_LX_100 = 3'b100,
		AOTP_L1_14 = 3'b101,
		AOTP_L1_12 = 3'b110,
		AOTP_L1_16 = 3'b111
	} aotp_lane_e;

endpackage

// [verilog/aotp_cmd_if.sv]
// Command carrier between the serial word shifter and the register bank.
// Assumes both ends share one clock.
`timescale 1ns/1ps

interface aotp_cmd_if;
	logic wr_stb;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic sdo_oe;

	modport shifter (
		output wr_stb,
		output addr,
		output wdata,
		output sdo_oe,
		input rdata
	);

	modport bank (
		input wr_stb,
		input addr,
		input wdata,
		input sdo_oe,
		output rdata
	);
endinterface

// [verilog/aotp_shifter.sv]
// Serial word shifter: samples the synchronised pins, builds 16-bit commands.
// Assumes cs_n, sck and sdi have already passed two flip-flops.
`timescale 1ns/1ps
`include "aotp_defines.svh"

module aotp_shifter (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic sdi,
	aotp_cmd_if.shifter cmd
);
	import aotp_pkg::*;

	logic sck_d_reg;
	logic [4:0] cnt_reg;
	logic [14:0] sr_reg;
	logic rw_reg;
	logic load_reg;
	logic [7:0] rd_sh_reg;
	logic sdo_oe_reg;
	logic wr_stb_reg;
	logic [6:0] addr_reg;
	logic [7:0] wdata_reg;
	logic rise;
	logic fall;

	assign rise = sck & ~sck_d_reg & ~cs_n;
	assign fall = ~sck & sck_d_reg & ~cs_n;
	assign cmd.wr_stb = wr_stb_reg;
	assign cmd.addr = addr_reg;
	assign cmd.wdata = wdata_reg;
	assign cmd.sdo_oe = sdo_oe_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sck_d_reg <= 1'b0;
		end else begin
			sck_d_reg <= sck;
		end
	end

	// Edges past the sixteenth are ignored; chip select high restarts the word.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 5'h00;
			sr_reg <= 15'h0000;
		end else if (cs_n) begin
			cnt_reg <= 5'h00;
		end else if (rise && cnt_reg < `AOTP_WORD_BITS) begin
			cnt_reg <= cnt_reg + 5'h01;
			sr_reg <= {sr_reg[13:0], sdi}; // see R11
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rw_reg <= 1'b0;
			addr_reg <= 7'h00;
			load_reg <= 1'b0;
		end else begin
			load_reg <= 1'b0;
			if (rise && cnt_reg == `AOTP_HDR_BITS - 5'h01) begin
				rw_reg <= sr_reg[6]; // see R11
				addr_reg <= {sr_reg[5:0], sdi};
				load_reg <= sr_reg[6];
			end
		end
	end

	// A write lands on the sixteenth edge; a read never updates a register.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_stb_reg <= 1'b0;
			wdata_reg <= 8'h00;
		end else begin
			wr_stb_reg <= 1'b0;
			if (rise && cnt_reg == `AOTP_WORD_BITS - 5'h01 && !rw_reg) begin
				wr_stb_reg <= 1'b1; // see R11
				wdata_reg <= {sr_reg[6:0], sdi};
			end
		end
	end

	// Open drain: the pin is pulled low while a zero data bit is shifted out.
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_sh_reg <= 8'h00;
			sdo_oe_reg <= 1'b0;
		end else if (cs_n || !rw_reg) begin
			sdo_oe_reg <= 1'b0;
		end else if (load_reg) begin
			rd_sh_reg <= cmd.rdata;
		end else if (fall && cnt_reg >= `AOTP_HDR_BITS && cnt_reg < `AOTP_WORD_BITS) begin
			sdo_oe_reg <= ~rd_sh_reg[7]; // see R11
			rd_sh_reg <= {rd_sh_reg[6:0], 1'b0};
		end else if (fall) begin
			sdo_oe_reg <= 1'b0;
		end
	end
endmodule // aotp_shifter

// [bench/aotp_props.sv]
// Checker for the output mode and test pattern register bank top ports.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module aotp_props (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic sdo_o,
	input wire logic sdo_oe,
	input wire aotp_pkg::aotp_sample_t ch1_sample,
	input wire aotp_pkg::aotp_sample_t ch2_sample,
	input wire aotp_pkg::aotp_sample_t ch1_word,
	input wire aotp_pkg::aotp_sample_t ch2_word,
	input wire logic [7:0] drive_current_x50ua,
	input wire logic current_valid,
	input wire logic internal_termination_on,
	input wire logic termination_misuse,
	input wire logic output_disable,
	input wire logic [2:0] lane_serialization_sel,
	input wire logic two_lane,
	input wire logic [4:0] ser_width,
	input wire logic format_valid,
	input wire logic test_pattern_on,
	input wire aotp_pkg::aotp_sample_t test_pattern
);
	import aotp_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	function automatic logic [4:0] width_of(input logic [2:0] m);
		case (m)
			3'h0, 3'h7: return 5'h10;
			3'h1, 3'h5: return 5'h0E;
			3'h2, 3'h6: return 5'h0C;
			default: return 5'h00;
		endcase
	endfunction
	words_zeroed_a: assert property (
		output_disable && $past(output_disable) |-> ch1_word == '0 && ch2_word == '0)
		else $error("words not zero while outputs disabled");
	pattern_sent_a: assert property (
		(test_pattern_on && !output_disable && $stable(test_pattern))[*2]
		|-> ch1_word == test_pattern && ch2_word == test_pattern)
		else $error("pattern not sent on both channels");
	samples_pass_a: assert property (
		(!test_pattern_on && !output_disable)[*2]
		|-> ch1_word == $past(ch1_sample) && ch2_word == $past(ch2_sample))
		else $error("samples not passed through");
	misuse_current_a: assert property (
		termination_misuse |-> internal_termination_on
		&& drive_current_x50ua inside {8'h00, 8'h78, 8'h8C, 8'hA0, 8'hB4})
		else $error("misuse flag with wrong current");
	doubled_current_a: assert property (
		internal_termination_on && !termination_misuse
		|-> drive_current_x50ua inside {8'h46, 8'h54, 8'h64})
		else $error("terminated current not doubled");
	plain_current_a: assert property (
		!internal_termination_on |-> !termination_misuse && drive_current_x50ua
		inside {8'h00, 8'h23, 8'h2A, 8'h32, 8'h3C, 8'h46, 8'h50, 8'h5A})
		else $error("unterminated current out of table");
	current_flag_a: assert property (
		current_valid == (drive_current_x50ua != 8'h00))
		else $error("current valid flag wrong");
	format_decode_a: assert property (
		ser_width == width_of(lane_serialization_sel)
		&& two_lane == !lane_serialization_sel[2] && format_valid == (ser_width != 5'h00))
		else $error("lane format decode wrong");
	sdo_release_a: assert property (
		cs_n[*8] |-> !sdo_oe && sdo_o == 1'b0)
		else $error("serial output not released");
	regs_quiet_a: assert property (
		cs_n[*8] |=> $stable(test_pattern) && $stable(test_pattern_on)
		&& $stable(lane_serialization_sel))
		else $error("register changed while deselected");
endmodule // aotp_props

bind aotp_regs aotp_props aotp_props_inst (
	.clock, .arst_n, .cs_n, .sdo_o, .sdo_oe, .ch1_sample, .ch2_sample, .ch1_word,
	.ch2_word, .drive_current_x50ua, .current_valid, .internal_termination_on,
	.termination_misuse, .output_disable, .lane_serialization_sel, .two_lane,
	.ser_width, .format_valid, .test_pattern_on, .test_pattern
);

// [bench/aotp_host_model.sv]
// Serial configuration host: sends 16-bit words, collects read data.
// Assumes SDO already resolved with its pull-up by the bench.
`timescale 1ns/1ps
module aotp_host_model (
	input wire logic clock,
	input wire logic go,
	input wire logic [15:0] word,
	input wire logic slow,
	input wire logic cut,
	input wire logic sdo,
	output logic busy,
	output logic [7:0] rdata,
	output logic cs_n,
	output logic sck,
	output logic sdi
);
	int h;
	initial begin
		busy = 1'b0;
		cs_n = 1'b1;
		sck = 1'b0;
		sdi = 1'b0;
		rdata = 8'h00;
		forever begin
			@(posedge clock);
			if (go) begin
				// Half periods stay well above the pin synchroniser latency.
				h = slow ? 10 : 6;
				busy <= 1'b1;
				cs_n <= 1'b0;
				for (int i = 15; i >= (cut ? 4 : 0); i--) begin
					sdi <= word[i];
					repeat (h - 1) @(posedge clock);
					@(negedge clock);
					if (i < 8) rdata[i] = sdo;
					@(posedge clock);
					sck <= 1'b1;
					repeat (h) @(posedge clock);
					sck <= 1'b0;
				end
				repeat (h) @(posedge clock);
				cs_n <= 1'b1;
				sdi <= ~sdi;
				repeat (h) @(posedge clock);
				busy <= 1'b0;
			end
		end
	end
endmodule // aotp_host_model

// [bench/aotp_regs_tb.sv]
// Self-checking bench for the output mode and test pattern registers.
// Assumes the host model on the serial pins and a pull-up on SDO.
`timescale 1ns/1ps
module aotp_regs_tb;
	import aotp_pkg::*;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic go = 1'b0;
	logic slow = 1'b0;
	logic cut = 1'b0;
	logic [15:0] word = 16'h0000;
	aotp_sample_t ch1_sample = 14'h1234;
	aotp_sample_t ch2_sample = 14'h2ABC;
	aotp_sample_t ch1_word, ch2_word, test_pattern;
	logic busy, cs_n, sck, sdi, sdo_o, sdo_oe, current_valid, internal_termination_on;
	logic termination_misuse, output_disable, two_lane, format_valid, test_pattern_on;
	logic [7:0] drive_current_x50ua, rdata;
	logic [2:0] lane_serialization_sel;
	logic [4:0] ser_width;
	logic [7:0] cur [8] = '{8'h46, 8'h50, 8'h5A, 8'h00, 8'h3C, 8'h32, 8'h2A, 8'h23};
	logic [4:0] wid [8] = '{5'h10, 5'h0E, 5'h0C, 5'h00, 5'h00, 5'h0E, 5'h0C, 5'h10};
	int fail_count = 0;
	int compares = 0;
	wire sdo = sdo_oe ? 1'b0 : 1'b1;
	always #20 clock = ~clock;
	aotp_regs aotp_regs_inst (.clock, .arst_n, .cs_n, .sck, .sdi, .sdo_o, .sdo_oe,
		.ch1_sample, .ch2_sample, .ch1_word, .ch2_word, .drive_current_x50ua,
		.current_valid, .internal_termination_on, .termination_misuse, .output_disable,
		.lane_serialization_sel, .two_lane, .ser_width, .format_valid, .test_pattern_on,
		.test_pattern);
	aotp_host_model aotp_host_model_inst (.clock, .go, .word, .slow, .cut, .sdo, .busy,
		.rdata, .cs_n, .sck, .sdi);
	task automatic conclude;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic [15:0] w);
		word <= w;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
		repeat (600) begin
			@(negedge clock);
			if (!busy) break;
		end
		// A host that never finishes its word counts as a failure of the run.
		if (busy) begin
			fail_count++;
			conclude();
		end
		@(posedge clock);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		xfer({1'b0, a, d});
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		xfer({1'b1, a, 8'h00});
		chk(16'(rdata), 16'(exp));
	endtask
	initial begin
		repeat (3) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		chk(16'({two_lane, ser_width, format_valid, test_pattern_on}), 16'h00C2);
		chk(16'(ch1_word), 16'h1234);
		xfer(16'h0080);
		for (int t = 0; t < 16; t++) begin
			wr(7'h02, {t[2:0], t[3], 4'h0});
			chk(16'(drive_current_x50ua), 16'(cur[t[2:0]]) << t[3]);
			chk(16'({current_valid, internal_termination_on, termination_misuse}),
				16'({t[2:0] != 3, t[3], t[3] && t[2:0] < 5}));
		end
		for (int t = 0; t < 8; t++) begin
			wr(7'h02, {5'h00, t[2:0]});
			chk(16'({lane_serialization_sel, two_lane, ser_width, format_valid}),
				16'({t[2:0], !t[2], wid[t], wid[t] != 5'h00}));
		end
		slow <= 1'b1;
		rd(7'h02, 8'h07);
		slow <= 1'b0;
		wr(7'h02, 8'h08);
		chk(16'({output_disable, ch1_word}), 16'h4000);
		chk(16'(ch2_word), 16'h0000);
		wr(7'h04, 8'hA5);
		wr(7'h03, 8'hFF);
		rd(7'h03, 8'hBF);
		chk(16'({test_pattern_on, test_pattern}), 16'h7FA5);
		chk(16'(ch1_word), 16'h0000);
		wr(7'h02, 8'h00);
		chk(16'(ch1_word), 16'h3FA5);
		chk(16'(ch2_word), 16'h3FA5);
		ch1_sample <= 14'h0F0F;
		wr(7'h03, 8'h3F);
		chk(16'({test_pattern_on, ch1_word}), 16'h0F0F);
		wr(7'h05, 8'hFF);
		rd(7'h05, 8'h00);
		cut <= 1'b1;
		wr(7'h04, 8'h00);
		cut <= 1'b0;
		rd(7'h04, 8'hA5);
		chk(16'(test_pattern), 16'h3FA5);
		xfer(16'h0080);
		chk(16'(test_pattern), 16'h0000);
		rd(7'h02, 8'h00);
		conclude();
	end
	initial begin
		repeat (40000) @(posedge clock);
		fail_count++;
		conclude();
	end
endmodule // aotp_regs_tb
